/* File: bench/drive_sync_monitor_tb_top.sv */
module drive_sync_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Scaled timing: fast 125, slow 250 cycles
  localparam logic [15:0] FAST = 16'h007D;
  localparam logic [23:0] SLOW = 24'h0000FA;
  localparam int          NSLW = 250;
  logic        sys_clk     = 1'b0;
  logic        rst         = 1'b1;
  logic        run         = 1'b0;
  logic [15:0] cfg_width   = 16'h0032;
  logic [15:0] cfg_fast    = 16'h007D;
  logic [23:0] ctrl_cycle  = 24'h0000FA;
  logic [23:0] comm_cycle  = 24'h0000FA;
  logic [31:0] tx_data     = 32'hC0DE1234;
  logic        tx_for_me   = 1'b1;
  logic        tx_crc_err  = 1'b0;
  logic        fault_reset = 1'b0;
  logic        fast_pulse;
  logic        slow_pulse;
  logic        pd_valid;
  logic        estop;
  logic [31:0] pd_data;
  logic [15:0] fault_code;
  int          miscompares = 0;
  int          cmp_count   = 0;
  always #10 sys_clk = ~sys_clk;
  dsm_link_if u_dsm_link_if ();
  dsm_device #(.P_FAST_62_CYC(32'h1F), .P_FAST_125_CYC(32'h3E), .P_FAST_250_CYC(32'h7D))
  u_dsm_device (.SYS_CLK(sys_clk), .RST(rst), .LINK(u_dsm_link_if),
    .CTRL_CYCLE(ctrl_cycle), .COMM_CYCLE(comm_cycle), .FAULT_RESET(fault_reset),
    .FAST_PULSE(fast_pulse), .SLOW_PULSE(slow_pulse), .PD_DATA(pd_data),
    .PD_VALID(pd_valid), .FAULT_CODE(fault_code), .ESTOP(estop));
  dsm_master #(.LEAD_CYC(32'h4)) u_dsm_master (.SYS_CLK(sys_clk), .RST(rst),
    .LINK(u_dsm_link_if), .RUN(run), .CFG_FAST_PERIOD(cfg_fast), .CFG_SLOW_PERIOD(SLOW),
    .CFG_PULSE_WIDTH(cfg_width), .TX_DATA(tx_data), .TX_FOR_ME(tx_for_me),
    .TX_CRC_ERR(tx_crc_err), .TX_TAKE());
  dsm_link_chk u_dsm_link_chk (.SYS_CLK(sys_clk), .RST(rst),
    .fast_en(u_dsm_link_if.fast_en), .slow_en(u_dsm_link_if.slow_en),
    .fast_period(u_dsm_link_if.fast_period), .slow_period(u_dsm_link_if.slow_period),
    .pulse_width(u_dsm_link_if.pulse_width), .telegram_end(u_dsm_link_if.telegram_end),
    .telegram_for_me(u_dsm_link_if.telegram_for_me),
    .telegram_crc_err(u_dsm_link_if.telegram_crc_err),
    .telegram_data(u_dsm_link_if.telegram_data), .slow_pulse(u_dsm_link_if.slow_pulse));
  // ==========
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    check_val({31'h0, got}, {31'h0, exp});
  endtask
  task automatic ack;
    fault_reset <= 1'b1;
    cyc(1);
    fault_reset <= 1'b0;
    cyc(3);
  endtask
  // Reset, start the segment, settle, then acknowledge start-up faults
  task automatic boot(input logic [15:0] w);
    rst <= 1'b1;
    run <= 1'b0;
    cfg_width <= w;
    ctrl_cycle <= SLOW;
    comm_cycle <= SLOW;
    cyc(10);
    rst <= 1'b0;
    cyc(2);
    run <= 1'b1;
    cyc(3 * NSLW);
    ack();
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    rst <= 1'b1;
    cyc(10);
    rst <= 1'b0;
    cyc(5);
    check_val(fault_code, dsm_pkg::CODE_FAST_OFF);
    check_flag(estop, 1'b1);
    ack();
    check_val(fault_code, dsm_pkg::CODE_FAST_OFF);
    $display("test reset done");
  endtask
  task automatic t_normal;
    int hi = 0;
    int per = 0;
    boot(16'h0032);
    tx_data <= 32'h5A5A0F0F;
    for (int i = 0; i < 600 && fast_pulse !== 1'b0; i++) @(posedge sys_clk);
    for (int i = 0; i < 600 && fast_pulse !== 1'b1; i++) @(posedge sys_clk);
    while (fast_pulse === 1'b1 && per < 600) begin
      hi++;
      per++;
      @(posedge sys_clk);
    end
    while (fast_pulse !== 1'b1 && per < 600) begin
      per++;
      @(posedge sys_clk);
    end
    check_val(hi, dsm_pkg::PULSE_W_CYC);
    check_val(per, 32'h7D);
    cyc(NSLW);
    for (int i = 0; i < 600 && pd_valid !== 1'b1; i++) @(posedge sys_clk);
    check_flag(pd_valid, 1'b1);
    check_val(pd_data, 32'h5A5A0F0F);
    check_val(fault_code, dsm_pkg::CODE_NONE);
    check_flag(estop, 1'b0);
    $display("test normal done");
  endtask
  task automatic t_width;
    boot(16'h0028);
    cyc(NSLW);
    check_val(fault_code, dsm_pkg::CODE_WIDTH);
    check_flag(estop, 1'b1);
    $display("test width done");
  endtask
  task automatic t_mismatch;
    boot(16'h0032);
    comm_cycle <= 24'h000177;
    cyc(5);
    check_val(fault_code, dsm_pkg::CODE_MISMATCH);
    ack();
    check_val(fault_code, dsm_pkg::CODE_MISMATCH);
    $display("test mismatch done");
  endtask
  task automatic t_cfg;
    cfg_fast <= 16'h0064;
    boot(16'h0032);
    check_val(fault_code, dsm_pkg::CODE_CYCLE_CFG);
    check_flag(estop, 1'b1);
    cfg_fast <= FAST;
    $display("test config done");
  endtask
  task automatic t_skip;
    for (int i = 0; i < 2; i++) begin
      tx_crc_err <= (i == 0);
      tx_for_me <= (i == 0);
      boot(16'h0032);
      cyc(3 * NSLW);
      check_val(fault_code, dsm_pkg::CODE_DATA_SYNC);
      check_flag(estop, 1'b1);
    end
    $display("test skip done");
  endtask
  // ==========
  // Verdict
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_normal();
    t_width();
    t_mismatch();
    t_cfg();
    t_skip();
    results();
  end
  initial begin
    cyc(20000);
    miscompares++;
    results();
  end
endmodule // drive_sync_monitor_tb_top

/* File: bench/dsm_link_chk.sv */
module dsm_link_chk (
  input logic        SYS_CLK,
  input logic        RST,
  input logic        fast_en,
  input logic        slow_en,
  input logic [15:0] fast_period,
  input logic [23:0] slow_period,
  input logic [15:0] pulse_width,
  input logic        telegram_end,
  input logic        telegram_for_me,
  input logic        telegram_crc_err,
  input logic [31:0] telegram_data,
  input logic        slow_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Slow pulse high-time and period counters
  logic [15:0] hcnt_r;
  logic [23:0] pcnt_r;
  logic        prev_r;
  logic        seen_r;
  logic        per_ok_r;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      hcnt_r <= 16'h0000;
      pcnt_r <= 24'h000000;
      prev_r <= 1'b0;
      seen_r <= 1'b0;
      per_ok_r <= 1'b0;
    end else begin
      prev_r <= slow_pulse;
      hcnt_r <= slow_pulse ? hcnt_r + 16'h0001 : 16'h0000;
      pcnt_r <= (slow_pulse && !prev_r) ? 24'h000001 : pcnt_r + 24'h000001;
      // First pulse after enable is short, so skip it
      seen_r <= slow_en && (seen_r || (prev_r && !slow_pulse));
      // First period after enable is one short as well
      per_ok_r <= slow_en && (per_ok_r || (seen_r && slow_pulse && !prev_r));
    end
  end
  // ==========
  // Link properties
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  slow_off_quiet_a: assert property (!slow_en [*3] |-> !slow_pulse)
    else $error("slow pulse while disabled");
  tel_one_cycle_a: assert property (telegram_end |=> !telegram_end)
    else $error("telegram end longer than one cycle");
  tel_enabled_a: assert property (telegram_end |-> fast_en && slow_en)
    else $error("telegram while pulses disabled");
  // Lead window sized for a short master lead
  tel_before_pulse_a: assert property (telegram_end && slow_en |->
    !slow_pulse ##[1:40] $rose(slow_pulse))
    else $error("telegram not just before slow pulse");
  cfg_stable_a: assert property (fast_en && $past(fast_en) |->
    $stable(fast_period) && $stable(slow_period) && $stable(pulse_width))
    else $error("pulse settings changed while enabled");
  en_pair_a: assert property (fast_en == slow_en)
    else $error("pulse enables differ");
  slow_width_a: assert property ($fell(slow_pulse) && seen_r && slow_en |->
    hcnt_r == pulse_width)
    else $error("slow pulse high time wrong");
  slow_period_a: assert property ($rose(slow_pulse) && per_ok_r |->
    pcnt_r == slow_period)
    else $error("slow pulse period wrong");
  cover property (telegram_end && telegram_for_me && !telegram_crc_err);
  cover property (telegram_end && telegram_crc_err);
  cover property ($rose(slow_pulse) && seen_r);
endmodule // dsm_link_chk

/* File: hw/dsm_device.sv */
module dsm_device #(
  parameter int P_FAST_62_CYC  = dsm_pkg::FAST_62_CYC,
  parameter int P_FAST_125_CYC = dsm_pkg::FAST_125_CYC,
  parameter int P_FAST_250_CYC = dsm_pkg::FAST_250_CYC
) (
  input  wire logic                       SYS_CLK,
  input  wire logic                       RST,
  dsm_link_if.dev                         LINK,
  input  wire logic [dsm_pkg::SLOW_W-1:0] CTRL_CYCLE,
  input  wire logic [dsm_pkg::SLOW_W-1:0] COMM_CYCLE,
  input  wire logic                       FAULT_RESET,
  output logic                            FAST_PULSE,
  output logic                            SLOW_PULSE,
  output logic [dsm_pkg::DATA_W-1:0]      PD_DATA,
  output logic                            PD_VALID,
  output logic [15:0]                     FAULT_CODE,
  output logic                            ESTOP
);
  // ==========================================================================
  // Parameter check
  if (P_FAST_62_CYC < 2 || P_FAST_125_CYC < 2 || P_FAST_250_CYC < 2 ||
      P_FAST_250_CYC + dsm_pkg::MISS_MARGIN_CYC >= 2**dsm_pkg::FAST_W) begin : g_chk
    $error("dsm_device: fast period counts out of range");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [dsm_pkg::FAST_W-1:0] fcnt;
    logic [dsm_pkg::SLOW_W-1:0] scnt;
    logic                       fpulse;
    logic                       spulse;
    logic                       fprev;
    logic                       sprev;
    logic [15:0]                fwid;
    logic [15:0]                swid;
    logic [dsm_pkg::FAST_W-1:0] fgap;
    logic [dsm_pkg::SLOW_W-1:0] sgap;
    logic [dsm_pkg::DATA_W-1:0] buf_data;
    logic                       written;
    logic                       skipped;
    logic [dsm_pkg::DATA_W-1:0] pd_data;
    logic                       pd_valid;
    logic                       ev_missing;
    logic                       ev_width;
    logic                       ev_skip;
    logic                       ev_align;
    logic [15:0]                code;
    logic                       estop;
  } dsm_dev_state_t;

  dsm_dev_state_t s_r;
  dsm_dev_state_t s_nxt;

  function automatic logic [15:0] dsm_encode(input logic cyc_bad, input logic fast_off,
                                             input logic slow_off, input logic mism,
                                             input logic miss, input logic wid,
                                             input logic skip);
    if (cyc_bad)       return dsm_pkg::CODE_CYCLE_CFG;
    else if (fast_off) return dsm_pkg::CODE_FAST_OFF;
    else if (slow_off) return dsm_pkg::CODE_SLOW_OFF;
    else if (mism)     return dsm_pkg::CODE_MISMATCH;
    else if (miss)     return dsm_pkg::CODE_MISSING;
    else if (wid)      return dsm_pkg::CODE_WIDTH;
    else if (skip)     return dsm_pkg::CODE_DATA_SYNC;
    else               return dsm_pkg::CODE_NONE;
  endfunction

  logic                       fast_ok;
  logic                       fast_rise;
  logic                       slow_rise;
  logic                       mismatch;
  logic                       clr;
  logic [dsm_pkg::FAST_W-1:0] fast_limit;
  logic [dsm_pkg::SLOW_W-1:0] slow_limit;

  always_comb begin
    s_nxt = s_r;
    fast_ok = LINK.fast_period == P_FAST_62_CYC[dsm_pkg::FAST_W-1:0] ||
              LINK.fast_period == P_FAST_125_CYC[dsm_pkg::FAST_W-1:0] ||
              LINK.fast_period == P_FAST_250_CYC[dsm_pkg::FAST_W-1:0];
    // ========================================================================
    // Pulse generation
    // fast and slow pulse generators
    if (!LINK.fast_en || LINK.fast_period == '0) begin
      s_nxt.fcnt = '0;
    end else if (s_r.fcnt >= LINK.fast_period - 1'b1) begin
      s_nxt.fcnt = '0;
    end else begin
      s_nxt.fcnt = s_r.fcnt + 1'b1;
    end
    if (!LINK.slow_en || LINK.slow_period == '0) begin
      s_nxt.scnt = '0;
    end else if (s_r.scnt >= LINK.slow_period - 1'b1) begin
      s_nxt.scnt = '0;
    end else begin
      s_nxt.scnt = s_r.scnt + 1'b1;
    end
    s_nxt.fpulse = LINK.fast_en && s_nxt.fcnt < LINK.pulse_width;
    s_nxt.spulse = LINK.slow_en && {8'h00, s_nxt.scnt[15:0]} < {8'h00, LINK.pulse_width}
                   && s_nxt.scnt[23:16] == 8'h00;
    // ========================================================================
    // Edge monitor
    s_nxt.fprev = s_r.fpulse;
    s_nxt.sprev = s_r.spulse;
    fast_rise = s_r.fpulse && !s_r.fprev;
    slow_rise = s_r.spulse && !s_r.sprev;
    s_nxt.pd_valid = 1'b0;
    s_nxt.ev_missing = 1'b0;
    s_nxt.ev_width = 1'b0;
    s_nxt.ev_skip = 1'b0;
    s_nxt.ev_align = 1'b0;
    if (s_r.fpulse) begin
      s_nxt.fwid = fast_rise ? 16'h0001 : s_r.fwid + 16'h0001;
    end else if (s_r.fprev && s_r.fwid != 16'(dsm_pkg::PULSE_W_CYC)) begin
      s_nxt.ev_width = 1'b1;
    end
    if (s_r.spulse) begin
      s_nxt.swid = slow_rise ? 16'h0001 : s_r.swid + 16'h0001;
    end else if (s_r.sprev && s_r.swid != 16'(dsm_pkg::PULSE_W_CYC)) begin
      s_nxt.ev_width = 1'b1;
    end
    // missing limit is period plus margin
    fast_limit = LINK.fast_period + dsm_pkg::FAST_W'(dsm_pkg::MISS_MARGIN_CYC);
    slow_limit = LINK.slow_period + dsm_pkg::SLOW_W'(dsm_pkg::MISS_MARGIN_CYC);
    if (!LINK.fast_en || !fast_ok || fast_rise) begin
      s_nxt.fgap = '0;
    end else if (s_r.fgap >= fast_limit) begin
      s_nxt.fgap = '0;
      s_nxt.ev_missing = 1'b1;
    end else begin
      s_nxt.fgap = s_r.fgap + 1'b1;
    end
    if (!LINK.slow_en || LINK.slow_period == '0 || slow_rise) begin
      s_nxt.sgap = '0;
    end else if (s_r.sgap >= slow_limit) begin
      s_nxt.sgap = '0;
      s_nxt.ev_missing = 1'b1;
    end else begin
      s_nxt.sgap = s_r.sgap + 1'b1;
    end
    // slow edge must coincide with a fast edge
    if (slow_rise && !fast_rise) begin
      s_nxt.ev_align = 1'b1;
    end
    // ========================================================================
    // Process data path
    // copy only from a written buffer
    if (slow_rise) begin
      if (s_r.written) begin
        s_nxt.pd_data = s_r.buf_data;
        s_nxt.pd_valid = 1'b1;
        s_nxt.written = 1'b0;
        s_nxt.skipped = 1'b0;
      end else begin
        s_nxt.ev_skip = s_r.skipped;
        s_nxt.skipped = 1'b1;
      end
    end
    if (LINK.telegram_end && LINK.telegram_for_me && !LINK.telegram_crc_err) begin
      s_nxt.buf_data = LINK.telegram_data;
      s_nxt.written = 1'b1;
    end
    // ========================================================================
    // Fault latch
    // slow period against cycle times
    mismatch = LINK.slow_period != CTRL_CYCLE || LINK.slow_period != COMM_CYCLE;
    clr = FAULT_RESET;
    if (s_r.code != dsm_pkg::CODE_NONE && !clr) begin
      s_nxt.code = s_r.code;
    end else begin
      s_nxt.code = dsm_encode(LINK.fast_en && !fast_ok, !LINK.fast_en, !LINK.slow_en,
                              mismatch || s_nxt.ev_align, s_nxt.ev_missing,
                              s_nxt.ev_width, s_nxt.ev_skip);
    end
    s_nxt.estop = s_nxt.code != dsm_pkg::CODE_NONE;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign LINK.slow_pulse = s_r.spulse;
  assign FAST_PULSE = s_r.fpulse;
  assign SLOW_PULSE = s_r.spulse;
  assign PD_DATA    = s_r.pd_data;
  assign PD_VALID   = s_r.pd_valid;
  assign FAULT_CODE = s_r.code;
  assign ESTOP      = s_r.estop;
endmodule // dsm_device

/* File: hw/dsm_master.sv */
module dsm_master #(
  parameter int LEAD_CYC = dsm_pkg::TEL_LEAD_CYC
) (
  input  wire logic                       SYS_CLK,
  input  wire logic                       RST,
  dsm_link_if.mst                         LINK,
  input  wire logic                       RUN,
  input  wire logic [dsm_pkg::FAST_W-1:0] CFG_FAST_PERIOD,
  input  wire logic [dsm_pkg::SLOW_W-1:0] CFG_SLOW_PERIOD,
  input  wire logic [15:0]                CFG_PULSE_WIDTH,
  input  wire logic [dsm_pkg::DATA_W-1:0] TX_DATA,
  input  wire logic                       TX_FOR_ME,
  input  wire logic                       TX_CRC_ERR,
  output logic                            TX_TAKE
);
  // ==========================================================================
  // Parameter check
  if (LEAD_CYC < 1 || LEAD_CYC >= 2**dsm_pkg::SLOW_W) begin : g_chk
    $error("dsm_master: LEAD_CYC out of range");
  end

  typedef struct packed {
    logic                       run_prev;
    logic                       fast_en;
    logic                       slow_en;
    logic [dsm_pkg::FAST_W-1:0] fast_period;
    logic [dsm_pkg::SLOW_W-1:0] slow_period;
    logic [15:0]                width;
    logic                       sprev;
    logic [dsm_pkg::SLOW_W-1:0] cnt;
    logic                       tel_end;
    logic                       for_me;
    logic                       crc_err;
    logic [dsm_pkg::DATA_W-1:0] data;
  } dsm_mst_state_t;

  dsm_mst_state_t m_r;
  dsm_mst_state_t m_nxt;

  always_comb begin
    m_nxt = m_r;
    m_nxt.run_prev = RUN;
    m_nxt.sprev = LINK.slow_pulse;
    m_nxt.tel_end = 1'b0;
    if (RUN && !m_r.run_prev) begin
      m_nxt.fast_period = CFG_FAST_PERIOD;
      m_nxt.slow_period = CFG_SLOW_PERIOD;
      m_nxt.width = CFG_PULSE_WIDTH;
      m_nxt.fast_en = 1'b1;
      m_nxt.slow_en = 1'b1;
    end else if (!RUN) begin
      m_nxt.fast_en = 1'b0;
      m_nxt.slow_en = 1'b0;
    end
    // Cycles since last slow pulse edge
    if (LINK.slow_pulse && !m_r.sprev) begin
      m_nxt.cnt = dsm_pkg::SLOW_W'(1);
    end else begin
      m_nxt.cnt = m_r.cnt + 1'b1;
    end
    // telegram ends LEAD_CYC-1 cycles before slow pulse rises
    if (m_r.slow_en && m_r.slow_period > dsm_pkg::SLOW_W'(LEAD_CYC) &&
        m_r.cnt == m_r.slow_period - dsm_pkg::SLOW_W'(LEAD_CYC)) begin
      m_nxt.tel_end = 1'b1;
      m_nxt.data = TX_DATA;
      m_nxt.for_me = TX_FOR_ME;
      m_nxt.crc_err = TX_CRC_ERR;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      m_r <= '0;
    end else begin
      m_r <= m_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign LINK.fast_en          = m_r.fast_en;
  assign LINK.slow_en          = m_r.slow_en;
  assign LINK.fast_period      = m_r.fast_period;
  assign LINK.slow_period      = m_r.slow_period;
  assign LINK.pulse_width      = m_r.width;
  assign LINK.telegram_end     = m_r.tel_end;
  assign LINK.telegram_for_me  = m_r.for_me;
  assign LINK.telegram_crc_err = m_r.crc_err;
  assign LINK.telegram_data    = m_r.data;
  assign TX_TAKE               = m_r.tel_end;
endmodule // dsm_master

/* File: pkg/dsm_link_if.sv */
interface dsm_link_if;
  logic                      fast_en;
  logic                      slow_en;
  logic [dsm_pkg::FAST_W-1:0] fast_period;
  logic [dsm_pkg::SLOW_W-1:0] slow_period;
  logic [15:0]               pulse_width;
  logic                      telegram_end;
  logic                      telegram_for_me;
  logic                      telegram_crc_err;
  logic [dsm_pkg::DATA_W-1:0] telegram_data;
  logic                      slow_pulse;

  modport dev (
    input  fast_en, slow_en, fast_period, slow_period, pulse_width,
    input  telegram_end, telegram_for_me, telegram_crc_err, telegram_data,
    output slow_pulse
  );
  modport mst (
    output fast_en, slow_en, fast_period, slow_period, pulse_width,
    output telegram_end, telegram_for_me, telegram_crc_err, telegram_data,
    input  slow_pulse
  );
endinterface : dsm_link_if

/* File: pkg/dsm_pkg.sv */
// Summary of operation
// - Fast pulse default 250 us, drive aligns.
// - Missing fast pulse raises F414, emergency stop.
// - Fast period only 62.5/125/250 us, else F409.
// - Fast pulse output disabled raises F410.
// - Fast pulse width off standard raises F411.
// - Slow period multiple, equals cycle times, else F412.
// - Slow pulse output disabled raises F413.
// - Missing slow pulse raises F414, emergency stop.
// - Slow pulse width off standard raises F411.
// - Every synchronization fault triggers emergency stop ramp.
// - Telegram end stores data if addressed, CRC-clean.
// - Stored telegram marks output buffer written.
// - Slow pulse copies data only when written.
// - Two skipped copies in a row raise F415.
// - Master ends telegram just before slow pulse.
// - Master delivers output data on time only while slow pulses are enabled and the slow period exceeds LEAD_CYC.
// - Master configures pulse settings at every startup.
// - Fault stays until removed and reset acknowledged.
package dsm_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_NS         = 20;
  localparam int FAST_62_NS     = 62500;
  localparam int FAST_125_NS    = 125000;
  localparam int FAST_250_NS    = 250000;
  localparam int FAST_62_CYC    = FAST_62_NS / CLK_NS;
  localparam int FAST_125_CYC   = FAST_125_NS / CLK_NS;
  localparam int FAST_250_CYC   = FAST_250_NS / CLK_NS;
  localparam int PULSE_W_NS     = 1000;
  localparam int PULSE_W_CYC    = (PULSE_W_NS + CLK_NS - 1) / CLK_NS;
  localparam int MISS_MARGIN_CYC = 8;
  localparam int TEL_LEAD_NS    = 2000;
  localparam int TEL_LEAD_CYC   = TEL_LEAD_NS / CLK_NS;
  // ==========================================================================
  // Widths and fault codes
  localparam int FAST_W = 16;
  localparam int SLOW_W = 24;
  localparam int DATA_W = 32;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_CYCLE_CFG = 16'hF409;
  localparam logic [15:0] CODE_FAST_OFF  = 16'hF410;
  localparam logic [15:0] CODE_WIDTH     = 16'hF411;
  localparam logic [15:0] CODE_MISMATCH  = 16'hF412;
  localparam logic [15:0] CODE_SLOW_OFF  = 16'hF413;
  localparam logic [15:0] CODE_MISSING   = 16'hF414;
  localparam logic [15:0] CODE_DATA_SYNC = 16'hF415;
endpackage : dsm_pkg
